// file: pkg/atc_regs.vh
// Behaviour
// - writing control register aborts running sequence only
// - resolution bit 0 gives 10 bits, 1 gives 8
// - first sample phase always two conversion clocks
// - second phase 2, 4, 8 or 16 clocks
// - conversion clock is bus over 2*(divider+1)
// - divider field resets to five, divide twelve
`ifndef ATC_REGS_VH
`define ATC_REGS_VH
`define ATC_ADDR_W          4
`define ATC_OFS_CTRL        4'h0
`define ATC_OFS_STATUS      4'h4
`define ATC_OFS_CMD         4'h8
`define ATC_CTRL_RESET      8'h05
`define ATC_BIT_LOWRES      7
`define ATC_SMP_HI          6
`define ATC_SMP_LO          5
`define ATC_DIV_HI          4
`define ATC_DIV_LO          0
`define ATC_PHASE1_LEN      5'h02
`define ATC_SMP2_LEN0       5'h02
`define ATC_SMP2_LEN1       5'h04
`define ATC_SMP2_LEN2       5'h08
`define ATC_SMP2_LEN3       5'h10
`define ATC_LANE0           0
`define ATC_BITS_HI         4'ha
`define ATC_BITS_LO         4'h8
`define ATC_CMD_START       0
`define ATC_ST_BUSY         0
`define ATC_ST_DONE         1
`define ATC_ST_ABORT        2
`endif

// file: core/atc_timing_ctrl.v
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "atc_regs.vh"
// timing and resolution control for the approximation converter.
//
// the control byte holds three fields: the result width, the length of
// the second sample phase and the conversion clock divider. the divider
// feeds a counter that runs on the bus clock and toggles a half period
// each time it reaches the divider value, so the conversion clock is a
// bus clock enable rather than a second clock. this keeps the block in
// one clock domain at the cost of edges placed only on bus clock edges.
//
// the sequencer here is a minimal stand-in that walks sample phase 1,
// sample phase 2 and one step per result bit, all paced by the
// conversion clock. the real start register and the analog side sit in
// neighbouring blocks; a command offset stands in for the start write.
//
// limitation: the divider is not checked against the bus rate, so a
// divider that puts the conversion clock outside its legal window is
// accepted as written.
module atc_timing_ctrl (
   clk,
   rst,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_byteenable,
   avs_readdata,
   avs_waitrequest,
   conv_clk_en,
   conv_clk_out,
   seq_busy,
   seq_phase,
   bit_count,
   abort_pulse
);
   // clock and asynchronous reset
   input  wire        clk;
   input  wire        rst;

   // register bus slave; only byte lane 0 carries register bits
   input  wire [3:0]  avs_address;
   input  wire        avs_read;
   input  wire        avs_write;
   input  wire [31:0] avs_writedata;
   input  wire [3:0]  avs_byteenable;
   output reg  [31:0] avs_readdata;
   output wire        avs_waitrequest;

   // conversion clock and sequencer view
   output wire        conv_clk_en;
   output wire        conv_clk_out;
   output wire        seq_busy;
   output wire [3:0]  seq_phase;
   output wire [3:0]  bit_count;
   output wire        abort_pulse;

   // one-hot sequencer states; a stray code is sent back to idle by the
   // default branch of the next state logic
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_SMP1 = 4'h2;
   localparam [3:0] ST_SMP2 = 4'h4;
   localparam [3:0] ST_CONV = 4'h8;

   // control byte and prescaler
   reg  [7:0]  ctrl_r;
   reg  [4:0]  pre_cnt_r;
   reg         half_r;
   reg         tick_r;

   // sequencer
   reg  [3:0]  state_r;
   reg  [3:0]  state_nxt;
   reg  [4:0]  phase_cnt_r;
   reg  [4:0]  phase_cnt_nxt;
   reg  [3:0]  bits_r;
   reg  [3:0]  bits_nxt;

   // status flags, bus handshake and read data source
   reg         done_r;
   reg         aborted_r;
   reg         abort_r;
   reg         ack_r;
   reg  [31:0] rd_nxt;

   // control fields
   wire [4:0] div_val    = ctrl_r[`ATC_DIV_HI:`ATC_DIV_LO];
   wire [1:0] smp_sel    = ctrl_r[`ATC_SMP_HI:`ATC_SMP_LO];
   wire       low_res    = ctrl_r[`ATC_BIT_LOWRES];

   // bus decode; a write only lands in the cycle that waitrequest is low
   wire       access     = avs_read | avs_write;
   wire       rd_req     = avs_read & ~ack_r;
   wire       lane0      = avs_byteenable[`ATC_LANE0];
   wire       wr_ctrl    = avs_write & ack_r & (avs_address == `ATC_OFS_CTRL) & lane0;
   wire       wr_start   = avs_write & ack_r & (avs_address == `ATC_OFS_CMD) & lane0
                           & avs_writedata[`ATC_CMD_START];

   // sequencer events
   wire       seq_idle   = (state_r == ST_IDLE);
   wire       start_ok   = wr_start & seq_idle;      // a start while busy is ignored
   wire       seq_abort  = wr_ctrl & ~seq_idle;
   wire       seq_done   = (state_r == ST_CONV) & (state_nxt == ST_IDLE) & ~wr_ctrl;
   wire       pre_wrap   = (pre_cnt_r >= div_val);   // >= also catches a lowered divider

   // second sample phase length in conversion clocks; five bits hold the
   // longest choice
   function [4:0] smp_len;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    smp_len = `ATC_SMP2_LEN0;
            2'h1:    smp_len = `ATC_SMP2_LEN1;
            2'h2:    smp_len = `ATC_SMP2_LEN2;
            default: smp_len = `ATC_SMP2_LEN3;
         endcase
      end
   endfunction

   // result bit steps for the chosen resolution; fewer steps, shorter run
   function [3:0] res_bits;
      input lo;
      begin
         if (lo) begin
            res_bits = `ATC_BITS_LO;
         end else begin
            res_bits = `ATC_BITS_HI;
         end
      end
   endfunction

   // one wait state: waitrequest drops in the cycle after the request shows.
   // ack_r marks that second cycle and clears itself, so a request held over
   // back to back transfers still gets its wait state every time.
   assign avs_waitrequest = access & ~ack_r;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= access & ~ack_r;
      end
   end

   // every accepted write replaces the whole byte, even with the same value,
   // and the sequencer logic below treats it as an abort while a sequence runs
   // control register; reset value
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `ATC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= avs_writedata[7:0];
      end
   end

   // read mux, unmapped offsets read zero; status is read only
   always @* begin
      case (avs_address)
         `ATC_OFS_CTRL:   rd_nxt = {24'h000000, ctrl_r};
         `ATC_OFS_STATUS: rd_nxt = {29'h0, aborted_r, done_r, seq_busy};
         default:         rd_nxt = 32'h0000_0000;
      endcase
   end

   // read data latched in the request cycle so it stands when waitrequest drops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_req) begin
         avs_readdata <= rd_nxt;
      end
   end

   // half_r is the conversion clock itself; tick_r is the enable that the
   // sequencer steps on, raised once per full period after its high half.
   // a divider written mid-count already applies to the half period under way
   // reloading prescaler counter
   // divide by 2*(n+1): each full count is one half period, so never above clk/2
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_cnt_r <= 5'h00;
         half_r    <= 1'b0;
         tick_r    <= 1'b0;
      end else if (pre_wrap) begin
         pre_cnt_r <= 5'h00;
         half_r    <= ~half_r;
         tick_r    <= half_r;      // one enable per full conversion period
      end else begin
         pre_cnt_r <= pre_cnt_r + 5'h01;
         tick_r    <= 1'b0;
      end
   end

   assign conv_clk_en  = tick_r;
   assign conv_clk_out = half_r;

   // sequencer next state, stepped on conversion clock enables apart from a start or a control write.
   // idle waits for a start; sample phase 1 counts a fixed two enables;
   // sample phase 2 counts the selected length; converting counts one
   // enable per result bit. a control write overrides every branch, so
   // it wins over a phase end that falls in the same cycle.
   always @* begin
      state_nxt     = state_r;
      phase_cnt_nxt = phase_cnt_r;
      bits_nxt      = bits_r;
      case (state_r)
         ST_IDLE: begin
            // only a start leaves idle; a control write never does
            if (wr_start) begin
               state_nxt     = ST_SMP1;
               phase_cnt_nxt = 5'h00;
            end
         end
         ST_SMP1: begin
            if (tick_r) begin
               phase_cnt_nxt = phase_cnt_r + 5'h01;
               if (phase_cnt_r + 5'h01 == `ATC_PHASE1_LEN) begin
                  state_nxt     = ST_SMP2;
                  phase_cnt_nxt = 5'h00;
               end
            end
         end
         ST_SMP2: begin
            if (tick_r) begin
               phase_cnt_nxt = phase_cnt_r + 5'h01;
               if (phase_cnt_r + 5'h01 == smp_len(smp_sel)) begin
                  state_nxt = ST_CONV;
                  bits_nxt  = res_bits(low_res);
               end
            end
         end
         ST_CONV: begin
            // one step per result bit, then back to idle
            if (tick_r) begin
               bits_nxt = bits_r - 4'h1;
               if (bits_r == 4'h1) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            // an illegal code falls back to idle
            state_nxt = ST_IDLE;
         end
      endcase
      if (wr_ctrl) begin
         state_nxt     = ST_IDLE;
         phase_cnt_nxt = 5'h00;
         bits_nxt      = 4'h0;
      end
   end

   // sequencer registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r     <= ST_IDLE;
         phase_cnt_r <= 5'h00;
         bits_r      <= 4'h0;
      end else begin
         state_r     <= state_nxt;
         phase_cnt_r <= phase_cnt_nxt;
         bits_r      <= bits_nxt;
      end
   end

   // sticky done and aborted flags, cleared by a start. the setting events
   // need a busy sequencer and the clearing start needs an idle one, so a
   // set and a clear never share a cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         done_r    <= 1'b0;
         aborted_r <= 1'b0;
         abort_r   <= 1'b0;
      end else begin
         abort_r <= seq_abort;
         if (seq_done) begin
            done_r <= 1'b1;
         end else if (start_ok) begin
            done_r <= 1'b0;
         end
         if (seq_abort) begin
            aborted_r <= 1'b1;
         end else if (start_ok) begin
            aborted_r <= 1'b0;
         end
      end
   end

   // sequencer view for the neighbouring blocks; seq_phase, bit_count and abort_pulse
   // come straight from flip-flops, while seq_busy is decoded from state_r
   assign seq_busy    = ~seq_idle;
   assign seq_phase   = state_r;
   assign bit_count   = bits_r;
   assign abort_pulse = abort_r;

   // frequency window is software's job; not checked here.
   // the divider gives 2 to 64 bus clocks per conversion clock, so the
   // bus rate alone decides which divider values land inside the window;
   // nothing here refuses an out of range choice, and a conversion run
   // with one simply goes faster or slower than the analog side allows.
endmodule // atc_timing_ctrl

// file: test/atc_chk_assertions.sv
`timescale 1ns/1ps
// checks sequencer timing against a shadow of the control byte
module atc_chk (
   input logic        clk,
   input logic        rst,
   input logic [3:0]  avs_address,
   input logic        avs_write,
   input logic [31:0] avs_writedata,
   input logic        avs_waitrequest,
   input logic        conv_clk_en,
   input logic        seq_busy,
   input logic [3:0]  seq_phase,
   input logic        abort_pulse
);
   logic [7:0] ctl_r;
   logic [3:0] ph_r;
   logic [6:0] pc_r, gp_r, pc_nxt;
   logic       ok_r, wr;
   // accepted control write; pulses seen in the present state
   assign wr = avs_write && !avs_waitrequest && avs_address == 4'h0;
   assign pc_nxt = (seq_phase != ph_r ? 7'h0 : pc_r) + {6'h0, conv_clk_en};
   // spacing is trusted only between pulses with no write between them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_r <= 8'h05;
         ok_r <= 1'b0;
         ph_r <= 4'h1;
         pc_r <= 7'h0;
         gp_r <= 7'h0;
      end else begin
         if (wr) ctl_r <= avs_writedata[7:0];
         ok_r <= (ok_r | conv_clk_en) & !wr & (gp_r != 7'h7f);
         ph_r <= seq_phase;
         pc_r <= pc_nxt;
         gp_r <= conv_clk_en ? 7'h1 : gp_r + 7'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_abort; wr && seq_busy |=> abort_pulse && !seq_busy; endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   // a start may land right behind the write, so only the next cycle is fixed
   property p_idle; wr && !seq_busy |=> !seq_busy && !abort_pulse; endproperty
   a_idle: assert property (p_idle) else $error("started");
   property p_ph1; $rose(seq_phase == 4'h4) |-> $past(pc_nxt) == 7'h2; endproperty
   a_ph1: assert property (p_ph1) else $error("phase one");
   property p_ph2; $rose(seq_phase == 4'h8) |-> $past(pc_nxt) == 7'h2 << ctl_r[6:5]; endproperty
   a_ph2: assert property (p_ph2) else $error("phase two");
   property p_bits;
      $fell(seq_phase == 4'h8) && !abort_pulse |-> $past(pc_nxt) == (ctl_r[7] ? 7'h8 : 7'ha);
   endproperty
   a_bits: assert property (p_bits) else $error("bits");
   property p_per; conv_clk_en && ok_r |-> gp_r == {1'b0, ctl_r[4:0], 1'b0} + 7'h2; endproperty
   a_per: assert property (p_per) else $error("period");
   property p_half; conv_clk_en |=> !conv_clk_en; endproperty
   a_half: assert property (p_half) else $error("too fast");
   cover property (wr && seq_busy);
   cover property ($fell(seq_phase == 4'h8) && !abort_pulse);
   cover property (conv_clk_en && ok_r);
endmodule // atc_chk

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h1;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic        avs_waitrequest, conv_clk_en, conv_clk_out, seq_busy, abort_pulse;
   logic [3:0]  seq_phase, bit_count;
   int          fails = 0, checks = 0, cyc = 0, n;
   atc_timing_ctrl u_dut (.*);
   always #4 clk = ~clk;
   // hang guard, far beyond the expected run
   always @(posedge clk) if (++cyc == 20000) begin
      fails++;
      summarize();
   end
   task automatic summarize;
      $display("%0d checks, %0d fails", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge, then released
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // whole sequence at the slowest divider, the only legal one at this bus rate
   task automatic conv(input logic [1:0] smp, input logic lo);
      bus(1, 4'h0, {24'h0, lo, smp, 5'h1f}); // legal clock
      bus(1, 4'h8, 32'h1);
      n = 0;
      do begin
         @(negedge clk);
         n += conv_clk_en;
      end while (seq_busy !== 1'b0);
      chk(n, 2 + (2 << smp) + (lo ? 8 : 10)); // pulse total
      chk(bit_count, 32'h0); // every bit step used
      bus(0, 4'h4, 32'h0);
      chk(q, 32'h2); // done, not busy
   endtask
   // control write in mid-conversion must stop it
   task automatic abrt;
      bus(1, 4'h8, 32'h1);
      repeat (1400) @(posedge clk);
      @(negedge clk);
      chk(seq_phase, 32'h8); // converting
      bus(1, 4'h0, 32'h1f);
      @(negedge clk);
      chk({abort_pulse, seq_busy}, 2'b10); // stop flagged
      chk(bit_count, 32'h0); // steps cleared
      bus(0, 4'h4, 32'h0);
      chk(q, 32'h4); // aborted, no restart
   endtask
   // conversion clock period, one rise of conv_clk_out to the next
   task automatic per(input logic [4:0] dv);
      bus(1, 4'h0, {24'h0, 3'h0, dv});
      @(negedge clk);
      while (conv_clk_out !== 1'b0) @(negedge clk);
      while (conv_clk_out !== 1'b1) @(negedge clk);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (conv_clk_out !== 1'b0);
      do begin
         @(negedge clk);
         n++;
      end while (conv_clk_out !== 1'b1);
      chk(n, 2 * (dv + 1)); // divide by 2*(n+1)
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      bus(0, 4'h0, 32'h0);
      chk(q, 32'h5); // reset divider
      bus(0, 4'hc, 32'h0);
      chk(q, 32'h0);
      per(5'h00); // fastest is half the bus clock
      per(5'h05); // divide by twelve
      for (int i = 0; i < 4; i++) conv(i[1:0], i[0]); // every code
      abrt();
      summarize();
   end
endmodule // tb_top
bind atc_timing_ctrl atc_chk u_chk (.*);
